// *** hdl/ipc_pkg.sv ***
/*
 Shared constants and types for the inset picture control register bank:
 subaddresses, field positions, reset values, timing figures, state codes.
 Assumes a single 100 MHz system clock domain for all users.
*/
package ipc_pkg;

	// Serial bus device address, 7 bits (write byte 8'hD6)
	localparam logic [6:0] IPC_DEV_ADDR_DEFAULT = 7'h6B;

	// Subaddresses
	localparam logic [7:0] IPC_SUB_LOOP = 8'h00;
	localparam logic [7:0] IPC_SUB_HPOS_HI = 8'h01;
	localparam logic [7:0] IPC_SUB_HPOS_LO = 8'h02;
	localparam logic [7:0] IPC_SUB_VPOS = 8'h03;
	localparam logic [7:0] IPC_SUB_LUMA_AUX = 8'h04;
	localparam logic [7:0] IPC_SUB_STD_DECIM = 8'h05;
	localparam logic [7:0] IPC_SUB_HS_CLAMP = 8'h06;
	localparam logic [7:0] IPC_SUB_VS_GAIN = 8'h07;
	localparam logic [7:0] IPC_NUM_REGS = 8'h08;

	// Reset values
	localparam logic [7:0] IPC_REG_RESET = 8'h00;
	localparam logic [7:0] IPC_REG00_RESET = 8'h10;

	// Field positions
	localparam int IPC_LOOP_DISABLE_BIT = 4;
	localparam int IPC_HPOS_HI_LSB = 0;
	localparam int IPC_MIXED_BIT = 2;
	localparam int IPC_SEL_PHASE_LSB = 3;
	localparam int IPC_LUMA_LSB = 0;
	localparam int IPC_AUX_A_LSB = 3;
	localparam int IPC_AUX_B_LSB = 5;
	localparam int IPC_ISTD_LSB = 0;
	localparam int IPC_PSTD_LSB = 2;
	localparam int IPC_CHROMA_INV_BIT = 4;
	localparam int IPC_SYNC_SRC_BIT = 5;
	localparam int IPC_HDECIM_BIT = 6;
	localparam int IPC_VDECIM_BIT = 7;
	localparam int IPC_HSDEL_LSB = 0;
	localparam int IPC_CLK_SRC_BIT = 4;
	localparam int IPC_CLAMP_FIX_BIT = 5;
	localparam int IPC_CLAMP_CNT_BIT = 6;
	localparam int IPC_VSDEL_LSB = 0;
	localparam int IPC_VS_DENOISE_BIT = 5;
	localparam int IPC_GAIN_BIT = 7;

	// Timing
	localparam int IPC_MCLK_PERIOD_PS = 10000;
	localparam int IPC_VSYNC_STEP_PS = 2370000;
	localparam logic [12:0] IPC_VSYNC_STEP_CYC =
		13'(IPC_VSYNC_STEP_PS / IPC_MCLK_PERIOD_PS);
	localparam logic [6:0] IPC_HSYNC_UNIT_CLK = 7'h06;
	localparam logic [6:0] IPC_CLAMP_FIXED_CLK = 7'h00;

	// Decimation factors and clamp cycle counts
	localparam logic [2:0] IPC_DECIM_3 = 3'h3;
	localparam logic [2:0] IPC_DECIM_4 = 3'h4;
	localparam logic [1:0] IPC_CLAMP_THREE = 2'h3;
	localparam logic [1:0] IPC_CLAMP_TWO = 2'h2;

	typedef enum logic [1:0] {
		IPC_STD_AUTO = 2'h0,
		IPC_STD_625 = 2'h1,
		IPC_STD_525 = 2'h2,
		IPC_STD_HOLD = 2'h3
	} ipc_std_mode_t;

	typedef enum logic [1:0] {
		IPC_AUX_LOW = 2'h0,
		IPC_AUX_MID = 2'h1,
		IPC_AUX_HIGH = 2'h2
	} ipc_aux_level_t;

	typedef enum logic [4:0] {
		IPC_ST_IDLE = 5'h01,
		IPC_ST_ADDR = 5'h02,
		IPC_ST_SUB = 5'h04,
		IPC_ST_DATA = 5'h08,
		IPC_ST_ACK = 5'h10
	} ipc_state_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
	} ipc_bus_evt_t;

endpackage

// *** hdl/ipc_sync2.sv ***
/*
 Two flip-flop synchroniser for one asynchronous level.
 Assumes the input is a pin; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module ipc_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Level
	input wire logic i_d,
	output logic o_q
);
	logic meta_reg;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= RESET_VAL;
			o_q <= RESET_VAL;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule // ipc_sync2

// *** hdl/ipc_std_select.sv ***
/*
 Line standard selection for one video path: automatic, forced, or hold.
 Assumes the detector result is on the same clock and is 1 for 625 lines.
*/
`timescale 1ns/1ps
module ipc_std_select
	import ipc_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Mode and detector
	input wire logic [1:0] i_mode,
	input wire logic i_detected_625,
	// Effective standard
	output logic o_is_625
);
	// A forced standard that mismatches the signal is not corrected here
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_is_625 <= 1'b0;
		end else begin
			case (i_mode)
				IPC_STD_AUTO: o_is_625 <= i_detected_625;
				IPC_STD_625: o_is_625 <= 1'b1;
				IPC_STD_525: o_is_625 <= 1'b0;
				default: o_is_625 <= o_is_625;
			endcase
		end
	end
endmodule // ipc_std_select

// *** hdl/ipc_ctrl_regs.sv ***
/*
 Write-only control register bank behind a two-wire serial slave.
 Holds subaddresses 00 to 07 and drives the inset picture control fields.
 Assumes bus pins are asynchronous and sampled by the 100 MHz clock; the
 bus clock is far slower (80 ns or more per period) so edges are seen.
*/
//
// Behaviour
// RULE1 - Horizontal position is ten bits: two high from 01, eight from 02.
// RULE2 - Host keeps horizontal position between 2 and 740.
// RULE3 - Host writes both position bytes in one field when crossing 255.
// RULE4 - Mixed display bit selects height by inset only or adapted.
// RULE5 - Select phase is a signed four-bit shift, zero means in phase.
// RULE6 - Vertical position is an eight-bit count of lines.
// RULE7 - Host keeps vertical position within 220 or 182 lines.
// RULE8 - Three-bit luminance delay, zero smallest, seven largest.
// RULE9 - Two aux outputs follow their fields: low, mid, high, high.
// RULE10 - Inset standard: auto, forced 625, forced 525, or hold.
// RULE11 - Parent standard uses the same four codes.
// RULE12 - Chroma polarity bit inverts both colour-difference inputs.
// RULE13 - Sync source bit picks separate syncs or combined sandcastle.
// RULE14 - Two bits pick horizontal and vertical decimation, 3 or 4.
// RULE15 - Four-bit inset hsync delay in units of six pixel clocks.
// RULE16 - Host uses one inset clock mode and never clears it back.
// RULE17 - Clamp pulses follow hsync delay unless clamp-fix is set.
// RULE18 - Clamp-count bit picks three or two clamp cycles per line.
// RULE19 - Five-bit inset vsync delay in steps of 2.37 microseconds.
// RULE20 - Vsync denoise bit enables noise reduction, normally zero.
// RULE21 - Gain bit doubles decimation filter gain, else unity.
// RULE22 - Only writes: address, subaddress, data bytes, auto-increment.
// RULE23 - At reset all bytes are zero except the loop-disable bit.
// RULE24 - A data byte lands in its register once acknowledged.
`timescale 1ns/1ps
module ipc_ctrl_regs
	import ipc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = IPC_DEV_ADDR_DEFAULT
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Two-wire serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// Line standard detectors
	input wire logic i_inset_detect_625,
	input wire logic i_parent_detect_625,
	// Position and select
	output logic [9:0] o_inset_hpos,
	output logic o_mixed_display_mode,
	output logic signed [3:0] o_overlay_select_phase,
	output logic [7:0] o_inset_vpos,
	// Luminance and auxiliary levels
	output logic [2:0] o_luma_delay,
	output logic [1:0] o_aux_level_out_a,
	output logic [1:0] o_aux_level_out_b,
	// Standards, input format, decimation
	output logic [1:0] o_inset_standard_sel,
	output logic [1:0] o_parent_standard_sel,
	output logic o_inset_is_625,
	output logic o_parent_is_625,
	output logic o_chroma_in_invert,
	output logic o_inset_sync_source,
	output logic o_horiz_decim_ratio,
	output logic o_vert_decim_ratio,
	output logic [2:0] o_horiz_decim_factor,
	output logic [2:0] o_vert_decim_factor,
	// Sync delays, clock and clamp
	output logic [3:0] o_inset_hsync_delay,
	output logic [6:0] o_inset_hsync_delay_clk,
	output logic o_inset_clock_source,
	output logic o_clamp_fixed,
	output logic o_clamp_count_sel,
	output logic [1:0] o_clamp_cycles,
	output logic [6:0] o_clamp_offset_clk,
	output logic [4:0] o_inset_vsync_delay,
	output logic [12:0] o_inset_vsync_delay_cyc,
	output logic o_inset_vsync_denoise,
	output logic o_decim_gain_double,
	output logic o_loop_disable
);
	logic scl_s;
	logic sda_s;
	logic scl_d_reg;
	logic sda_d_reg;
	ipc_bus_evt_t evt;
	ipc_state_t state_reg;
	ipc_state_t kind_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] subaddr_reg;
	logic [7:0] data_reg;
	logic [7:0] ctl_reg [0:7];
	logic receiving;
	logic byte_done;
	logic ack_end;
	logic addr_ok;
	logic wr_pulse;

	// Bus pins pass two flops before anything reads them
	ipc_sync2 #(
		.RESET_VAL(1'b1)
	) u_sync_scl (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_scl),
		.o_q(scl_s)
	);

	ipc_sync2 #(
		.RESET_VAL(1'b1)
	) u_sync_sda (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_sda),
		.o_q(sda_s)
	);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	always_comb begin
		evt.start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
		evt.stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
		evt.scl_rise = scl_s & ~scl_d_reg;
		evt.scl_fall = ~scl_s & scl_d_reg;
	end

	assign receiving = (state_reg == IPC_ST_ADDR) |
		(state_reg == IPC_ST_SUB) | (state_reg == IPC_ST_DATA);
	assign byte_done = receiving & evt.scl_fall & (bit_cnt_reg == 4'h8);
	assign ack_end = (state_reg == IPC_ST_ACK) & evt.scl_fall;
	// A read request is not acknowledged
	assign addr_ok = (shift_reg[7:1] == DEV_ADDR) & ~shift_reg[0]; // RULE22
	assign wr_pulse = ack_end & (kind_reg == IPC_ST_DATA); // RULE24

	// Transfer sequencing; start and stop win over any bit activity
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= IPC_ST_IDLE;
			kind_reg <= IPC_ST_IDLE;
		end else if (evt.stop) begin
			state_reg <= IPC_ST_IDLE;
		end else if (evt.start) begin
			state_reg <= IPC_ST_ADDR;
		end else begin
			case (state_reg)
				IPC_ST_IDLE: state_reg <= IPC_ST_IDLE;
				IPC_ST_ADDR, IPC_ST_SUB, IPC_ST_DATA: begin
					if (byte_done) begin
						kind_reg <= state_reg;
						if (state_reg == IPC_ST_ADDR && !addr_ok)
							state_reg <= IPC_ST_IDLE;
						else
							state_reg <= IPC_ST_ACK;
					end
				end
				IPC_ST_ACK: begin
					if (ack_end) begin
						case (kind_reg)
							IPC_ST_ADDR: state_reg <= IPC_ST_SUB; // RULE22
							IPC_ST_SUB: state_reg <= IPC_ST_DATA; // RULE22
							default: state_reg <= IPC_ST_DATA;
						endcase
					end
				end
				default: state_reg <= IPC_ST_IDLE;
			endcase
		end
	end

	// Bit counting and shifting, MSB first
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else if (evt.start || byte_done) begin
			bit_cnt_reg <= 4'h0;
		end else if (receiving && evt.scl_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			shift_reg <= {shift_reg[6:0], sda_s};
		end
	end

	// Acknowledge: pull the line low for the ninth clock
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_sda_out <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (evt.stop || evt.start || ack_end) begin
			o_sda_oe_n <= 1'b1;
		end else if (byte_done &&
			(state_reg != IPC_ST_ADDR || addr_ok)) begin
			o_sda_oe_n <= 1'b0; // RULE22
		end
	end

	// Subaddress pointer with auto-increment after each data byte
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			subaddr_reg <= IPC_SUB_LOOP;
			data_reg <= 8'h00;
		end else if (byte_done && state_reg == IPC_ST_SUB) begin
			subaddr_reg <= shift_reg;
		end else if (byte_done && state_reg == IPC_ST_DATA) begin
			data_reg <= shift_reg;
		end else if (wr_pulse) begin
			subaddr_reg <= subaddr_reg + 8'h01; // RULE22
		end
	end

	// Register storage; bytes aimed above 07 are acknowledged and dropped
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ctl_reg[0] <= IPC_REG00_RESET; // RULE23
			for (int k = 1; k < 8; k++) begin
				ctl_reg[k] <= IPC_REG_RESET; // RULE23
			end
		end else if (wr_pulse && subaddr_reg < IPC_NUM_REGS) begin
			ctl_reg[subaddr_reg[2:0]] <= data_reg; // RULE24
		end
	end

	// Fields straight from the stored bytes
	assign o_loop_disable = ctl_reg[0][IPC_LOOP_DISABLE_BIT];
	assign o_inset_hpos = {ctl_reg[1][IPC_HPOS_HI_LSB +: 2],
		ctl_reg[2]}; // RULE1
	assign o_mixed_display_mode = ctl_reg[1][IPC_MIXED_BIT]; // RULE4
	assign o_overlay_select_phase =
		ctl_reg[1][IPC_SEL_PHASE_LSB +: 4]; // RULE5
	assign o_inset_vpos = ctl_reg[3]; // RULE6
	assign o_luma_delay = ctl_reg[4][IPC_LUMA_LSB +: 3]; // RULE8
	assign o_inset_standard_sel = ctl_reg[5][IPC_ISTD_LSB +: 2];
	assign o_parent_standard_sel = ctl_reg[5][IPC_PSTD_LSB +: 2];
	assign o_chroma_in_invert = ctl_reg[5][IPC_CHROMA_INV_BIT]; // RULE12
	assign o_inset_sync_source = ctl_reg[5][IPC_SYNC_SRC_BIT]; // RULE13
	assign o_horiz_decim_ratio = ctl_reg[5][IPC_HDECIM_BIT]; // RULE14
	assign o_vert_decim_ratio = ctl_reg[5][IPC_VDECIM_BIT]; // RULE14
	assign o_inset_hsync_delay = ctl_reg[6][IPC_HSDEL_LSB +: 4]; // RULE15
	// Stored as written; the host must not clear it once set
	assign o_inset_clock_source = ctl_reg[6][IPC_CLK_SRC_BIT]; // RULE16
	assign o_clamp_fixed = ctl_reg[6][IPC_CLAMP_FIX_BIT]; // RULE17
	assign o_clamp_count_sel = ctl_reg[6][IPC_CLAMP_CNT_BIT]; // RULE18
	assign o_inset_vsync_delay = ctl_reg[7][IPC_VSDEL_LSB +: 5]; // RULE19
	assign o_inset_vsync_denoise = ctl_reg[7][IPC_VS_DENOISE_BIT]; // RULE20
	assign o_decim_gain_double = ctl_reg[7][IPC_GAIN_BIT]; // RULE21

	// Line standard resolution for both paths
	ipc_std_select u_inset_std (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_mode(ctl_reg[5][IPC_ISTD_LSB +: 2]),
		.i_detected_625(i_inset_detect_625),
		.o_is_625(o_inset_is_625)
	); // RULE10

	ipc_std_select u_parent_std (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_mode(ctl_reg[5][IPC_PSTD_LSB +: 2]),
		.i_detected_625(i_parent_detect_625),
		.o_is_625(o_parent_is_625)
	); // RULE11

	// Auxiliary three-level outputs; code 11 folds onto high
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_aux_level_out_a <= IPC_AUX_LOW;
			o_aux_level_out_b <= IPC_AUX_LOW;
		end else begin
			o_aux_level_out_a <= ctl_reg[4][IPC_AUX_A_LSB + 1] ?
				IPC_AUX_HIGH : ctl_reg[4][IPC_AUX_A_LSB +: 2]; // RULE9
			o_aux_level_out_b <= ctl_reg[4][IPC_AUX_B_LSB + 1] ?
				IPC_AUX_HIGH : ctl_reg[4][IPC_AUX_B_LSB +: 2]; // RULE9
		end
	end

	// Decoded counts, one clock behind the stored fields
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_horiz_decim_factor <= IPC_DECIM_3;
			o_vert_decim_factor <= IPC_DECIM_3;
			o_clamp_cycles <= IPC_CLAMP_THREE;
		end else begin
			o_horiz_decim_factor <= ctl_reg[5][IPC_HDECIM_BIT] ?
				IPC_DECIM_4 : IPC_DECIM_3; // RULE14
			o_vert_decim_factor <= ctl_reg[5][IPC_VDECIM_BIT] ?
				IPC_DECIM_4 : IPC_DECIM_3; // RULE14
			o_clamp_cycles <= ctl_reg[6][IPC_CLAMP_CNT_BIT] ?
				IPC_CLAMP_TWO : IPC_CLAMP_THREE; // RULE18
		end
	end

	// Sync delays in clocks; the vsync delay is in system clock cycles
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_inset_hsync_delay_clk <= 7'h00;
			o_clamp_offset_clk <= IPC_CLAMP_FIXED_CLK;
			o_inset_vsync_delay_cyc <= 13'h0000;
		end else begin
			o_inset_hsync_delay_clk <= 7'(ctl_reg[6][IPC_HSDEL_LSB +: 4]) *
				IPC_HSYNC_UNIT_CLK; // RULE15
			o_clamp_offset_clk <= ctl_reg[6][IPC_CLAMP_FIX_BIT] ?
				IPC_CLAMP_FIXED_CLK :
				7'(ctl_reg[6][IPC_HSDEL_LSB +: 4]) *
				IPC_HSYNC_UNIT_CLK; // RULE17
			o_inset_vsync_delay_cyc <=
				13'(ctl_reg[7][IPC_VSDEL_LSB +: 5]) *
				IPC_VSYNC_STEP_CYC; // RULE19
		end
	end
endmodule // ipc_ctrl_regs

// *** verification/ipc_ctrl_regs_sva.sv ***
/*
 Port checker for ipc_ctrl_regs.
 Assumes a slow bus master: SCL low for at least five clocks.
*/
`timescale 1ns/1ps
module ipc_ctrl_regs_sva (
	// Clock, reset and bus
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_inset_detect_625,
	input wire logic o_sda_oe_n,
	// Fields
	input wire logic [9:0] o_inset_hpos,
	input wire logic [7:0] o_inset_vpos,
	input wire logic [1:0] o_aux_level_out_a,
	input wire logic [1:0] o_inset_standard_sel,
	input wire logic o_inset_is_625,
	input wire logic o_horiz_decim_ratio,
	input wire logic [2:0] o_horiz_decim_factor,
	input wire logic [3:0] o_inset_hsync_delay,
	input wire logic [6:0] o_inset_hsync_delay_clk,
	input wire logic o_clamp_fixed,
	input wire logic o_clamp_count_sel,
	input wire logic [1:0] o_clamp_cycles,
	input wire logic [6:0] o_clamp_offset_clk,
	input wire logic [4:0] o_inset_vsync_delay,
	input wire logic [12:0] o_inset_vsync_delay_cyc,
	input wire logic o_loop_disable
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	chk_hsync_scale: assert property (
		o_inset_hsync_delay_clk == 7'($past(o_inset_hsync_delay)) * 7'h06)
		else $error("hsync delay clocks wrong");
	chk_vsync_scale: assert property (
		o_inset_vsync_delay_cyc == 13'($past(o_inset_vsync_delay)) * 13'h0ED)
		else $error("vsync delay cycles wrong");
	chk_clamp_offset: assert property (
		o_clamp_offset_clk == ($past(o_clamp_fixed) ? 7'h00 :
		7'($past(o_inset_hsync_delay)) * 7'h06))
		else $error("clamp offset wrong");
	chk_clamp_cycles: assert property (
		o_clamp_cycles == ($past(o_clamp_count_sel) ? 2'h2 : 2'h3))
		else $error("clamp cycle count wrong");
	chk_decim_factor: assert property (
		o_horiz_decim_factor == ($past(o_horiz_decim_ratio) ? 3'h4 : 3'h3))
		else $error("decimation factor wrong");
	chk_aux_code: assert property (
		o_aux_level_out_a != 2'h3)
		else $error("aux level code out of range");
	chk_std_resolve: assert property (
		!$past(i_rst) && $past(o_inset_standard_sel) != 2'h3 |->
		o_inset_is_625 == (($past(o_inset_standard_sel) == 2'h0) ?
		$past(i_inset_detect_625) : ($past(o_inset_standard_sel) == 2'h1)))
		else $error("inset standard not resolved");
	chk_std_hold: assert property (
		!$past(i_rst) && $past(o_inset_standard_sel) == 2'h3 |->
		$stable(o_inset_is_625))
		else $error("held inset standard moved");
	chk_ack_scl_low: assert property (
		$changed(o_sda_oe_n) |-> !i_scl)
		else $error("data line changed while bus clock high");
	// Store and ack release share one edge, so the field moves with oe_n
	chk_field_update: assert property (
		$changed({o_inset_hpos, o_inset_vpos, o_loop_disable}) |->
		o_sda_oe_n && !$past(o_sda_oe_n))
		else $error("field moved outside an acked byte");

	cover property ($fell(o_sda_oe_n));
	cover property ($fell(o_loop_disable));
	cover property (o_inset_standard_sel == 2'h3 && o_inset_is_625);
endmodule // ipc_ctrl_regs_sva

bind ipc_ctrl_regs ipc_ctrl_regs_sva chk_u (.i_mclk, .i_rst, .i_scl,
	.i_inset_detect_625, .o_sda_oe_n, .o_inset_hpos, .o_inset_vpos,
	.o_aux_level_out_a, .o_inset_standard_sel, .o_inset_is_625,
	.o_horiz_decim_ratio, .o_horiz_decim_factor, .o_inset_hsync_delay,
	.o_inset_hsync_delay_clk, .o_clamp_fixed, .o_clamp_count_sel,
	.o_clamp_cycles, .o_clamp_offset_clk, .o_inset_vsync_delay,
	.o_inset_vsync_delay_cyc, .o_loop_disable);

// *** verification/ipc_bus_master.sv ***
/*
 Two-wire bus master model: start, bytes with ack sampling, stop.
 Assumes the bench builds the open-drain wire with a pull-up.
*/
`timescale 1ns/1ps
module ipc_bus_master (
	// Clock
	input wire logic i_mclk,
	// Bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// Bus clock idles high between frames
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// Low five clocks, high three: 80 ns per bit
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			tick(2);
			o_sda = (i < 0) ? 1'b1 : b[i];
			tick(3);
			o_scl = 1'b1;
			tick(3);
			ack = !i_sda;
			o_scl = 1'b0;
		end
	endtask

	task automatic write(input logic [7:0] a, input logic [7:0] d [$],
		output int nak);
		logic ak;
		nak = 0;
		o_sda = 1'b1;
		tick(2);
		o_scl = 1'b1;
		tick(3);
		o_sda = 1'b0;
		tick(3);
		o_scl = 1'b0;
		put_byte(a, ak);
		nak += int'(!ak);
		foreach (d[i]) begin
			put_byte(d[i], ak);
			nak += int'(!ak);
		end
		tick(2);
		o_sda = 1'b0;
		tick(3);
		o_scl = 1'b1;
		tick(3);
		o_sda = 1'b1;
		tick(4);
	endtask
endmodule // ipc_bus_master

// *** verification/testbench.sv ***
/*
 Self-checking bench for ipc_ctrl_regs against a register model.
 Assumes the bus master model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic det_i = 1'b0;
	logic det_p = 1'b0;
	logic m_scl, m_sda, li, lp;
	logic o_sda_out, o_sda_oe_n, o_mixed_display_mode, o_inset_is_625;
	logic o_parent_is_625, o_chroma_in_invert, o_inset_sync_source;
	logic o_horiz_decim_ratio, o_vert_decim_ratio, o_inset_clock_source;
	logic o_clamp_fixed, o_clamp_count_sel, o_inset_vsync_denoise;
	logic o_decim_gain_double, o_loop_disable;
	logic [1:0] o_aux_level_out_a, o_aux_level_out_b, o_clamp_cycles;
	logic [1:0] o_inset_standard_sel, o_parent_standard_sel;
	logic [2:0] o_luma_delay, o_horiz_decim_factor, o_vert_decim_factor;
	logic [3:0] o_inset_hsync_delay;
	logic signed [3:0] o_overlay_select_phase;
	logic [4:0] o_inset_vsync_delay;
	logic [6:0] o_inset_hsync_delay_clk, o_clamp_offset_clk;
	logic [7:0] o_inset_vpos;
	logic [9:0] o_inset_hpos;
	logic [12:0] o_inset_vsync_delay_cyc;
	logic [7:0] r [8];
	logic [31:0] seed = 32'h00000052;
	int mismatches = 0;
	int tests_run = 0;
	// Open drain with pull-up: released means high
	wire sda_w = (o_sda_oe_n ? 1'b1 : o_sda_out) & m_sda;

	always #5 i_mclk = ~i_mclk;

	ipc_bus_master m_u (.i_mclk, .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));

	ipc_ctrl_regs dut_u (.i_mclk, .i_rst, .i_scl(m_scl), .i_sda(sda_w),
		.o_sda_out, .o_sda_oe_n, .i_inset_detect_625(det_i),
		.i_parent_detect_625(det_p), .o_inset_hpos, .o_mixed_display_mode,
		.o_overlay_select_phase, .o_inset_vpos, .o_luma_delay,
		.o_aux_level_out_a, .o_aux_level_out_b, .o_inset_standard_sel,
		.o_parent_standard_sel, .o_inset_is_625, .o_parent_is_625,
		.o_chroma_in_invert, .o_inset_sync_source, .o_horiz_decim_ratio,
		.o_vert_decim_ratio, .o_horiz_decim_factor, .o_vert_decim_factor,
		.o_inset_hsync_delay, .o_inset_hsync_delay_clk, .o_inset_clock_source,
		.o_clamp_fixed, .o_clamp_count_sel, .o_clamp_cycles,
		.o_clamp_offset_clk, .o_inset_vsync_delay, .o_inset_vsync_delay_cyc,
		.o_inset_vsync_denoise, .o_decim_gain_double, .o_loop_disable);

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	function automatic logic res(input logic [1:0] m, input logic d, l);
		return (m == 2'h0) ? d : (m == 2'h1) ? 1'b1 : (m == 2'h2) ? 1'b0 : l;
	endfunction

	function automatic logic [1:0] aux(input logic [1:0] c);
		return c[1] ? 2'h2 : c;
	endfunction

	task automatic check(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_all();
		logic [6:0] m6;
		logic [12:0] m7;
		m6 = 7'(r[6][3:0] * 6);
		m7 = 13'(r[7][4:0] * 237);
		check("hpos", {r[1][1:0], r[2]}, o_inset_hpos);
		check("select", r[1][6:2],
			{o_overlay_select_phase, o_mixed_display_mode});
		check("vpos", r[3], o_inset_vpos);
		check("luma_aux", {r[4][2:0], aux(r[4][4:3]),
			aux(r[4][6:5])}, {o_luma_delay, o_aux_level_out_a,
			o_aux_level_out_b});
		check("std_decim", {r[5], li, lp,
			r[5][6] ? 3'h4 : 3'h3, r[5][7] ? 3'h4 : 3'h3},
			{o_vert_decim_ratio, o_horiz_decim_ratio, o_inset_sync_source,
			o_chroma_in_invert, o_parent_standard_sel, o_inset_standard_sel,
			o_inset_is_625, o_parent_is_625, o_horiz_decim_factor,
			o_vert_decim_factor});
		check("hs_clamp", {r[6][6:0], m6,
			r[6][6] ? 2'h2 : 2'h3, r[6][5] ? 7'h00 : m6},
			{o_clamp_count_sel, o_clamp_fixed, o_inset_clock_source,
			o_inset_hsync_delay, o_inset_hsync_delay_clk, o_clamp_cycles,
			o_clamp_offset_clk});
		check("vs_gain", {r[7][7], r[7][5:0], m7},
			{o_decim_gain_double, o_inset_vsync_denoise, o_inset_vsync_delay,
			o_inset_vsync_delay_cyc});
		check("loop_bus", {r[0][4], 2'h2},
			{o_loop_disable, o_sda_oe_n, o_sda_out});
	endtask

	task automatic do_reset();
		i_rst = 1'b1;
		repeat (3) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		foreach (r[i]) r[i] = 8'h00;
		r[0] = 8'h10;
		li = 1'b0;
		lp = 1'b0;
		check_all();
		m_u.tick(4);
	endtask

	// Whole bank from subaddress 00, one extra byte aimed past 07 is dropped
	task automatic rand_burst();
		logic [7:0] q [$];
		logic [7:0] x;
		logic [9:0] h;
		int nak;
		x = rnd();
		det_i = x[0];
		det_p = x[1];
		li = res(r[5][1:0], det_i, li);
		lp = res(r[5][3:2], det_p, lp);
		h = 10'(2 + {x, rnd()} % 739);
		x = rnd();
		r[0] = rnd();
		r[1] = {1'b0, x[6:2], h[9:8]};
		r[2] = h[7:0];
		r[3] = 8'(rnd() % 183);
		r[4] = rnd() & 8'h7F;
		r[5] = rnd();
		r[6] = (rnd() & 8'h6F) | (r[6] & 8'h10) | {3'h0, x[7], 4'h0};
		r[7] = rnd() & 8'hBF;
		q = {8'h00, r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7], rnd()};
		m_u.write(8'hD6, q, nak);
		check("acks", 0, nak);
		li = res(r[5][1:0], det_i, li);
		lp = res(r[5][3:2], det_p, lp);
		check_all();
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		int nak;
		do_reset();
		repeat (6) rand_burst();
		// Wrong address, then a read request: neither is acked nor stored
		for (int i = 0; i < 2; i++) begin
			m_u.write(i ? 8'hD7 : 8'hD8, '{8'h03, ~r[3]}, nak);
			check("refused", 3, nak);
			check_all();
		end
		do_reset();
		repeat (2) rand_burst();
		complete_run();
	end
endmodule // testbench
